// ==== tpwm_pkg.sv ====
package tpwm_pkg;
   localparam int          TPWM_NCH         = 2;
   localparam int          TPWM_W           = 16;
   // Register byte offsets
   localparam logic [7:0]  TPWM_OFS_CTRL    = 8'h00;
   localparam logic [7:0]  TPWM_OFS_MOD     = 8'h04;
   localparam logic [7:0]  TPWM_OFS_CNT     = 8'h08;
   localparam logic [7:0]  TPWM_OFS_CH0SC   = 8'h0c;
   localparam logic [7:0]  TPWM_OFS_CH0VAL  = 8'h10;
   localparam logic [7:0]  TPWM_OFS_CH1SC   = 8'h14;
   localparam logic [7:0]  TPWM_OFS_CH1VAL  = 8'h18;
   localparam logic [7:0]  TPWM_OFS_STAT    = 8'h1c;
   // Timer control fields
   localparam int          TPWM_CTRL_RUN    = 0;
   // Channel status and control fields
   localparam int          TPWM_SC_EN       = 0;
   localparam int          TPWM_SC_HIGH     = 1;
   localparam int          TPWM_SC_TOGGLE   = 2;
   localparam int          TPWM_SC_BUF      = 3;
   localparam int          TPWM_SC_FLAG     = 7;
   // Status register fields (overflow flag is write one to clear; ACT1 is read only)
   localparam int          TPWM_ST_OVF      = 0;
   localparam int          TPWM_ST_ACT1     = 8;
   // Reset values
   localparam logic [TPWM_W-1:0] TPWM_MOD_RST = 16'hffff;
   localparam logic [TPWM_W-1:0] TPWM_VAL_RST = 16'h0000;
   localparam logic [1:0]  TPWM_RESP_OKAY   = 2'b00;
   localparam logic [1:0]  TPWM_RESP_SLVERR = 2'b10;
endpackage

// ==== tpwm_core.sv ====
// The AXI4-Lite interface to the registers and the address map were decided locally.
`timescale 1ns/1ns
// Contract
// R1: Each channel makes unbuffered PWM; rewriting its compare value changes the width.
// R2: Unsynchronised writes act at once; a passed value gives no compare that period.
// R3: A smaller width written after overflow may be passed and missed that period.
// R4: Channel compare flag sets at the end of the pulse.
// R5: Overflow flag sets at the end of the PWM period.
// R6: Software shortens pulses from the compare handler.
// R7: Software lengthens pulses from the overflow handler.
// R8: Software should not use toggle mode for PWM.
// R9: Channels 0 and 1 link into one buffered PWM on the channel 0 pin.
// R10: Buffer select bit in channel 0 control establishes the link.
// R11: After entering buffered mode, channel 0 value sets the width first.
// R12: After a channel 1 write, channel 1 takes over at the next period.
// R13: At each overflow the most recently written set becomes active.
// R14: In buffered mode channel 0 control governs; channel 1 control has no effect.
// R15: While buffered, the channel 1 pin is released for general use.
// R16: Software writes only the inactive set while buffered.
// R17: Output goes active at overflow and inactive at compare match.
module tpwm_core
   import tpwm_pkg::*;
(
   input  wire logic                 aclk,
   input  wire logic                 aresetn,
   input  wire logic [7:0]           s_axi_awaddr,
   input  wire logic                 s_axi_awvalid,
   output logic                      s_axi_awready,
   input  wire logic [31:0]          s_axi_wdata,
   input  wire logic [3:0]           s_axi_wstrb,
   input  wire logic                 s_axi_wvalid,
   output logic                      s_axi_wready,
   output logic [1:0]                s_axi_bresp,
   output logic                      s_axi_bvalid,
   input  wire logic                 s_axi_bready,
   input  wire logic [7:0]           s_axi_araddr,
   input  wire logic                 s_axi_arvalid,
   output logic                      s_axi_arready,
   output logic [31:0]               s_axi_rdata,
   output logic [1:0]                s_axi_rresp,
   output logic                      s_axi_rvalid,
   input  wire logic                 s_axi_rready,
   output logic                      chan0_pin,
   output logic                      chan0_pin_oe,
   output logic                      chan1_pin,
   output logic                      chan1_pin_oe
);
   import tpwm_pkg::*;

   function automatic logic [TPWM_W-1:0] merge16(input logic [TPWM_W-1:0] old,
                                                 input logic [31:0] d,
                                                 input logic [3:0] be);
      merge16 = old;
      if (be[0]) merge16[7:0] = d[7:0];
      if (be[1]) merge16[15:8] = d[15:8];
   endfunction

   // Only aligned words inside the map answer OKAY
   function automatic logic addr_ok(input logic [7:0] a);
      addr_ok = (a[1:0] == 2'b00) && (a <= TPWM_OFS_STAT);
   endfunction

   // A disabled channel drives its pin low whatever the polarity
   function automatic logic pin_level(input logic en, input logic lvl, input logic high_act);
      pin_level = en & (lvl ^ ~high_act);
   endfunction

   logic              run;
   logic [TPWM_W-1:0] modulo;
   logic [TPWM_W-1:0] count;
   logic [7:0]        sc [TPWM_NCH];
   logic [TPWM_W-1:0] val [TPWM_NCH];
   logic              ovf_flag;
   logic              active1;
   logic              last1;
   logic [TPWM_NCH-1:0] pwm;

   // AXI write path: address and data latched independently
   // A pending response holds off new requests, so one write at a time
   logic        aw_held;
   logic        w_held;
   logic [7:0]  aw_addr;
   logic [31:0] w_data;
   logic [3:0]  w_strb;
   logic        wr_go;
   logic        wr_ok;

   assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
   assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
   assign wr_go = aw_held & w_held & ~s_axi_bvalid;
   assign wr_ok = addr_ok(aw_addr);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held  <= 1'b0;
         aw_addr <= 8'h00;
         w_data  <= 32'h0000_0000;
         w_strb  <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= TPWM_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? TPWM_RESP_OKAY : TPWM_RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // One strobe per register except the counter, high only in the cycle the write lands
   logic we_ctrl, we_mod, we_sc0, we_sc1, we_v0, we_v1, we_stat;
   assign we_ctrl = wr_go && aw_addr == TPWM_OFS_CTRL;
   assign we_mod  = wr_go && aw_addr == TPWM_OFS_MOD;
   assign we_sc0  = wr_go && aw_addr == TPWM_OFS_CH0SC;
   assign we_v0   = wr_go && aw_addr == TPWM_OFS_CH0VAL;
   assign we_sc1  = wr_go && aw_addr == TPWM_OFS_CH1SC;
   assign we_v1   = wr_go && aw_addr == TPWM_OFS_CH1VAL;
   assign we_stat = wr_go && aw_addr == TPWM_OFS_STAT;
   logic [TPWM_NCH-1:0] we_sc;
   assign we_sc = {we_sc1, we_sc0};

   // Counter and period
   // Count runs 0..modulo, so the period is modulo plus one cycles
   logic overflow;
   logic buffered;
   assign overflow = run && (count == modulo);
   // Channel 0 control alone decides whether the pair is linked
   assign buffered = sc[0][TPWM_SC_BUF]; // [R10]

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         run    <= 1'b0;
         modulo <= TPWM_MOD_RST;
      end else begin
         if (we_ctrl && w_strb[0]) run <= w_data[TPWM_CTRL_RUN];
         if (we_mod) modulo <= merge16(modulo, w_data, w_strb);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count <= '0;
      end else if (!run) begin
         count <= '0;
      end else if (overflow) begin
         count <= '0;
      end else begin
         count <= count + 16'h0001;
      end
   end

   // Values take effect at once; no shadowing in unbuffered use
   // A width already passed this period waits for the next one
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         val[0] <= TPWM_VAL_RST;
         val[1] <= TPWM_VAL_RST;
      end else begin
         if (we_v0) val[0] <= merge16(val[0], w_data, w_strb); // [R1] [R2] [R3]
         if (we_v1) val[1] <= merge16(val[1], w_data, w_strb); // [R1]
      end
   end

   // Buffered set selection
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         active1 <= 1'b0;
         last1   <= 1'b0;
      end else if (!buffered) begin
         active1 <= 1'b0; // [R11]
         last1   <= 1'b0;
      end else begin
         if (we_v1) last1 <= 1'b1;
         else if (we_v0) last1 <= 1'b0;
         // A value write on the overflow cycle itself counts as the latest
         if (overflow) active1 <= we_v1 ? 1'b1 : (we_v0 ? 1'b0 : last1); // [R12] [R13]
      end
   end

   // Compare matches and flags
   logic [TPWM_NCH-1:0] match;
   logic [TPWM_W-1:0]   buf_val;
   assign buf_val  = active1 ? val[1] : val[0];
   assign match[0] = run && (count == (buffered ? buf_val : val[0]));
   // Channel 1 compare is silenced while linked so its flag stays quiet
   assign match[1] = run && !buffered && (count == val[1]); // [R14]

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sc[0] <= 8'h00;
         sc[1] <= 8'h00;
      end else begin
         for (int i = 0; i < TPWM_NCH; i++) begin
            if (we_sc[i] && w_strb[0]) begin
               sc[i][6:0] <= w_data[6:0];
               // Clear by writing zero; the later set below wins a tie
               if (!w_data[TPWM_SC_FLAG]) sc[i][TPWM_SC_FLAG] <= 1'b0;
            end
            if (match[i] && sc[i][TPWM_SC_EN])
               sc[i][TPWM_SC_FLAG] <= 1'b1; // [R4]
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ovf_flag <= 1'b0;
      end else if (overflow) begin
         // Set beats a clear in the same cycle so no overflow is lost
         ovf_flag <= 1'b1; // [R5]
      end else if (we_stat && w_strb[0] && w_data[TPWM_ST_OVF]) begin
         ovf_flag <= 1'b0;
      end
   end

   // Output waveform; toggle mode kept for completeness though it cannot self-correct
   // Match beats overflow: a compare at the modulus holds the output inactive
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pwm <= '0;
      end else begin
         for (int i = 0; i < TPWM_NCH; i++) begin
            if (!sc[i][TPWM_SC_EN]) begin
               pwm[i] <= 1'b0;
            end else if (sc[i][TPWM_SC_TOGGLE]) begin
               if (match[i]) pwm[i] <= ~pwm[i]; // [R8]
            end else if (match[i]) begin
               pwm[i] <= 1'b0; // [R17]
            end else if (overflow) begin
               pwm[i] <= 1'b1; // [R17]
            end
         end
      end
   end

   // Channel 0 control steers the pair in buffered mode
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         chan0_pin    <= 1'b0;
         chan0_pin_oe <= 1'b0;
      end else begin
         chan0_pin    <= pin_level(sc[0][TPWM_SC_EN], pwm[0], sc[0][TPWM_SC_HIGH]); // [R9]
         chan0_pin_oe <= sc[0][TPWM_SC_EN]; // [R14]
      end
   end

   // While the pair is linked the channel 1 pin enable is held low; the pin level still follows channel 1 control
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         chan1_pin    <= 1'b0;
         chan1_pin_oe <= 1'b0;
      end else begin
         chan1_pin    <= pin_level(sc[1][TPWM_SC_EN], pwm[1], sc[1][TPWM_SC_HIGH]);
         chan1_pin_oe <= sc[1][TPWM_SC_EN] && !buffered; // [R15]
      end
   end

   // Read path
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0000_0000;
      case (s_axi_araddr)
         TPWM_OFS_CTRL:   rd_mux = {31'h0, run};
         TPWM_OFS_MOD:    rd_mux = {16'h0, modulo};
         TPWM_OFS_CNT:    rd_mux = {16'h0, count};
         TPWM_OFS_CH0SC:  rd_mux = {24'h0, sc[0]};
         TPWM_OFS_CH0VAL: rd_mux = {16'h0, val[0]};
         TPWM_OFS_CH1SC:  rd_mux = {24'h0, sc[1]};
         TPWM_OFS_CH1VAL: rd_mux = {16'h0, val[1]};
         TPWM_OFS_STAT:   rd_mux = {23'h0, active1, 7'h0, ovf_flag};
         default:         rd_mux = 32'h0000_0000;
      endcase
   end

   // Read data is captured on acceptance and stands until taken
   assign s_axi_arready = ~s_axi_rvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= TPWM_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_mux;
         s_axi_rresp  <= addr_ok(s_axi_araddr) ? TPWM_RESP_OKAY : TPWM_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule

// ==== tpwm_core_asserts.sv ====
`timescale 1ns/1ns
module tpwm_chk
   import tpwm_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        s_axi_awvalid,
   input  wire logic        s_axi_awready,
   input  wire logic        s_axi_wvalid,
   input  wire logic        s_axi_wready,
   input  wire logic        s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic        s_axi_arvalid,
   input  wire logic        s_axi_arready,
   input  wire logic        s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic [31:0] s_axi_rdata,
   input  wire logic [1:0]  s_axi_rresp,
   input  wire logic        chan0_pin
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   chk_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write accepted while response pending");
   chk_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read accepted while data pending");
   chk_b_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("write response late");
   chk_b_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response repeated");
   chk_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   chk_r_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read data repeated");
   chk_r_cause: assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arvalid))
      else $error("read data without request");
   chk_err_zero: assert property (s_axi_rvalid && s_axi_rresp == TPWM_RESP_SLVERR
      |-> s_axi_rdata == 32'h0)
      else $error("error read returned data");
   cover property (s_axi_bvalid);
   cover property (s_axi_rvalid && s_axi_rresp == TPWM_RESP_SLVERR);
   cover property ($rose(chan0_pin));
endmodule
bind tpwm_core tpwm_chk tpwm_chk_inst (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .chan0_pin);

// ==== tpwm_load.sv ====
`timescale 1ns/1ns
module tpwm_load (
   input  wire logic        aclk,
   input  wire logic        pin,
   input  wire logic        oe,
   output logic [15:0]      high_len,
   output logic [15:0]      period_len
);
   logic        prev = 1'b0;
   logic [15:0] hc   = 16'h0;
   logic [15:0] pc   = 16'h0;
   // The load only sees a level while the pin is driven
   always @(posedge aclk) begin
      prev <= pin & oe;
      if ((pin & oe) && !prev) begin // Pulse starts after overflow
         period_len <= pc;
         pc <= 16'h1;
         hc <= 16'h1;
      end else begin
         pc <= pc + 16'h1;
         if (pin & oe) hc <= hc + 16'h1;
      end
      if (!(pin & oe) && prev) high_len <= hc; // Pulse ends at compare
   end
endmodule

// ==== tpwm_core_bench.sv ====
`timescale 1ns/1ns
module tpwm_core_bench;
   import tpwm_pkg::*;
   logic        aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
   logic        s_axi_arvalid = 1'b0;
   logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        chan0_pin, chan0_pin_oe, chan1_pin, chan1_pin_oe;
   logic [15:0] high_len, period_len, high_len1, period_len1;
   logic [31:0] d;
   logic [1:0]  r;
   int          n_fail = 0, num_checks = 0;
   localparam int P = 10; // Period with the modulus set to P-1
   always #25 aclk = ~aclk;
   tpwm_core tpwm_core_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready(1'b1), .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready(1'b1), .chan0_pin,
      .chan0_pin_oe, .chan1_pin, .chan1_pin_oe);
   tpwm_load tpwm_load_inst (.aclk, .pin(chan0_pin), .oe(chan0_pin_oe), .high_len, .period_len);
   tpwm_load tpwm_load_ch1 (.aclk, .pin(chan1_pin), .oe(chan1_pin_oe), .high_len(high_len1),
      .period_len(period_len1));
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // Ready lines are sampled before the edge's updates land, so release follows the take
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      forever begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) begin
            r = s_axi_bresp;
            break;
         end
      end
   endtask
   task automatic rd(input logic [7:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      forever begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) begin
            d = s_axi_rdata;
            r = s_axi_rresp;
            break;
         end
      end
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      rd(a);
      chk($sformatf("reg %h", a), d & m, e);
   endtask
   // Software handler stand-in: wait until a flag reads back set
   task automatic poll(input logic [7:0] a, input logic [31:0] m);
      do rd(a); while ((d & m) == 32'h0);
   endtask
   task automatic width(input logic [15:0] e);
      repeat (3 * P) @(posedge aclk);
      chk("pulse width", 32'(high_len), 32'(e));
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      repeat (3000) @(posedge aclk);
      n_fail++;
      close_out();
   end
   initial begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rc(TPWM_OFS_MOD, 32'hffff, {16'h0, TPWM_MOD_RST});
      wr(TPWM_OFS_MOD, 32'(P - 1));
      wr(TPWM_OFS_CH1SC, 32'h1);
      wr(TPWM_OFS_CH0VAL, 32'h4);
      wr(TPWM_OFS_CH0SC, 32'h3);
      wr(TPWM_OFS_CTRL, 32'h1);
      chk("write resp", 32'(r), 32'(TPWM_RESP_OKAY));
      width(16'h5);
      chk("period", 32'(period_len), 32'(P));
      chk("ch1 width", 32'(high_len1), 32'(P - 1));
      chk("ch1 drive", 32'(chan1_pin_oe), 32'h1);
      rc(TPWM_OFS_STAT, 32'h1, 32'h1);
      rc(TPWM_OFS_CH0SC, 32'h80, 32'h80);
      wr(TPWM_OFS_STAT, 32'h1);
      poll(TPWM_OFS_STAT, 32'h1);
      wr(TPWM_OFS_CH0VAL, 32'h6);
      width(16'h7);
      wr(TPWM_OFS_CH0SC, 32'h3);
      poll(TPWM_OFS_CH0SC, 32'h80);
      wr(TPWM_OFS_CH0VAL, 32'h2);
      width(16'h3);
      rd(8'h20);
      chk("unmapped resp", 32'(r), 32'(TPWM_RESP_SLVERR));
      chk("unmapped data", d, 32'h0);
      wr(8'h22, 32'h5);
      chk("unmapped wresp", 32'(r), 32'(TPWM_RESP_SLVERR));
      wr(TPWM_OFS_CH0SC, 32'hb);
      repeat (2) @(posedge aclk);
      chk("ch1 released", 32'(chan1_pin_oe), 32'h0);
      width(16'h3);
      wr(TPWM_OFS_CH1VAL, 32'h5);
      width(16'h6);
      rc(TPWM_OFS_STAT, 32'h100, 32'h100);
      wr(TPWM_OFS_CH1SC, 32'h0);
      wr(TPWM_OFS_CH0VAL, 32'h8);
      width(16'h9);
      chk("ch0 drive", 32'(chan0_pin_oe), 32'h1);
      rc(TPWM_OFS_STAT, 32'h100, 32'h0);
      close_out();
   end
endmodule
